/* rtl/pcbc_monitor.sv */
// Performance monitor: four event counters and branch/cache event capture.
`timescale 1ns/1ps
`include "pcbc_defs.svh"
module pcbc_monitor
  import pcbc_pkg::*;
#(
  parameter int NCNT = 4,
  parameter int EW = 8
) (
  input wire logic clk, // Core clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic cp0_we, // Coprocessor register write strobe.
  input wire logic [4:0] cp0_reg, // Coprocessor register number.
  input wire logic [2:0] cp0_sel, // Register select.
  input wire logic [3:0] cp0_sel_hi, // Upper select bits, reserved space.
  input wire logic [63:0] cp0_wdata, // Write data.
  output logic [63:0] cp0_rdata_q, // Registered read data.
  input wire logic [63:0] ev_values, // Event active flags.
  input wire logic [EW-1:0] ev_amount [64], // Event increments.
  input wire pcbc_mode_t mode, // Current execution mode.
  input wire logic exl_active, // Exception level set.
  input wire logic br_valid, // Branch executed this cycle.
  input wire pcbc_br_class_t br_class, // Branch class.
  input wire logic br_pred_taken, // Conditional branch predicted taken.
  input wire logic br_taken, // Actual outcome taken.
  input wire logic br_mispredict, // Direction or target mispredicted.
  input wire logic [63:0] br_pc, // Branch virtual address.
  input wire logic iwatch_hit, // Instruction watch matched.
  input wire logic dwatch_hit, // Data watch matched.
  input wire logic ic_miss, // Instruction cache miss request.
  input wire logic dc_load, // Data cache load access.
  input wire logic dc_store, // Data cache store access.
  input wire logic [63:0] load_pc, // Virtual address of the load.
  input wire logic [39:0] miss_pa, // Physical address of the line.
  output logic irq_q, // Overflow interrupt, hardware line five.
  output logic cause_pending_q, // Cause pending bit seven set.
  output logic frozen_q // Counters and capture frozen.
);
  logic [31:0] ctl_rd [NCNT];
  logic [63:0] cnt_rd [NCNT];
  logic [NCNT-1:0] carry;
  logic [NCNT-1:0] fe;
  logic [NCNT-1:0] ie;
  logic [`PCBC_CAP_WIDTH-1:0] cap_q;
  logic [63:0] iaddr_q;
  logic [63:0] daddr_q;
  logic [63:0] iaddr_d;
  logic [63:0] daddr_d;
  logic [63:0] rdata_d;
  logic freeze_d;
  logic irq_d;
  logic sel_cnt;
  logic sel_cap;
  logic mu;
  logic ms;
  logic mk;
  logic cap_mode;
  logic pred_t;
  logic correct;
  logic f_res;
  logic f_pred;
  logic f_out;
  logic f_type;
  logic f_watch;
  logic br_hit;
  logic ic_hit;
  logic ld_hit;
  logic st_hit;
  logic cap_we;

  // Selects one class mask bit of the capture control register.
  function automatic logic class_mask(input pcbc_br_class_t c,
                                      input logic [20:0] r);
    logic m;
    m = 1'b0;
    case (c)
      PCBC_BR_COND: m = r[`PCBC_CAP_BCOND];
      PCBC_BR_UNCOND: m = r[`PCBC_CAP_BUNCOND];
      PCBC_BR_INDIRECT: m = r[`PCBC_CAP_BINDIR];
      PCBC_BR_CALL: m = r[`PCBC_CAP_BCALL];
      PCBC_BR_RETURN: m = r[`PCBC_CAP_BRET];
      default: m = 1'b0;
    endcase
    return m;
  endfunction : class_mask

  // Register decode; upper selects of register 25 are reserved.
  assign sel_cnt = (cp0_reg == `PCBC_REG_COUNTERS) &&
    (cp0_sel_hi == 4'h0);
  assign sel_cap = (cp0_reg == `PCBC_REG_CAPTURE) &&
    (cp0_sel_hi == 4'h0);

  // Execution mode decode.
  assign mu = (mode == PCBC_MODE_USER);
  assign ms = (mode == PCBC_MODE_SUPER);
  assign mk = (mode == PCBC_MODE_KERNEL);

  // The four counters; the last pair clears its next-pair flag.
  genvar gi;
  generate
    for (gi = 0; gi < NCNT; gi++) begin : g_cnt
      pcbc_counter #(
        .CW(41),
        .EW(EW),
        .PRESET(gi < NCNT - 1)
      ) u_cnt (
        .clk(clk),
        .reset_n(reset_n),
        .ev_values(ev_values),
        .ev_amount(ev_amount),
        .mode_ok_u(mu),
        .mode_ok_s(ms),
        .mode_ok_k(mk),
        .mode_ok_x(exl_active),
        .freeze(frozen_q),
        .ctl_we(cp0_we && sel_cnt && (cp0_sel == 3'(2 * gi))),
        .cnt_we(cp0_we && sel_cnt && (cp0_sel == 3'(2 * gi + 1))),
        .wdata(cp0_wdata),
        .ctl_rd(ctl_rd[gi]),
        .cnt_rd(cnt_rd[gi]),
        .carry_q(carry[gi]),
        .freeze_en_q(fe[gi]),
        .irq_en_q(ie[gi])
      );
    end
  endgenerate

  // Freeze follows any set carry flag whose freeze enable is set, so
  // it holds until software clears those flags.
  assign freeze_d = |(carry & fe);
  assign irq_d = |(carry & ie);

  // Capture mode filter shared by every source.
  assign cap_mode = (cap_q[`PCBC_CTL_USER] & mu) |
    (cap_q[`PCBC_CTL_SUPER] & ms) | (cap_q[`PCBC_CTL_KERNEL] & mk) |
    (cap_q[`PCBC_CTL_EXL] & exl_active);

  // Branch filters.
  assign pred_t = (br_class != PCBC_BR_COND) | br_pred_taken;
  assign correct = (br_class == PCBC_BR_UNCOND) | ~br_mispredict;
  assign f_res = correct ? cap_q[`PCBC_CAP_CC] : cap_q[`PCBC_CAP_CW];
  assign f_pred = pred_t ? cap_q[`PCBC_CAP_PT] : cap_q[`PCBC_CAP_PN];
  assign f_out = br_taken ? cap_q[`PCBC_CAP_OT] : cap_q[`PCBC_CAP_ONT];
  assign f_type = class_mask(br_class, cap_q);
  assign f_watch = ~cap_q[`PCBC_CAP_BWI] | iwatch_hit;
  assign br_hit = br_valid & cap_mode & f_res & f_pred & f_out &
    f_type & f_watch;

  // Cache event filters, one per access type.
  assign ic_hit = ic_miss & cap_mode & cap_q[`PCBC_CAP_IFETCH] &
    (~cap_q[`PCBC_CAP_CWI] | iwatch_hit);
  assign ld_hit = dc_load & cap_mode & cap_q[`PCBC_CAP_READ] &
    (~cap_q[`PCBC_CAP_CWD] | dwatch_hit) &
    (~cap_q[`PCBC_CAP_CWI] | iwatch_hit);
  assign st_hit = dc_store & cap_mode & cap_q[`PCBC_CAP_WRITE];

  // Event address capture, held while frozen.
  assign cap_we = cp0_we && sel_cap && (cp0_sel == `PCBC_SEL_CAP_CTRL);
  assign iaddr_d = frozen_q ? iaddr_q :
    (br_hit ? {br_pc[63:2],
      (br_taken ? `PCBC_TYPE_TAKEN : `PCBC_TYPE_NOTTAKEN)} :
    (ld_hit ? {load_pc[63:2], `PCBC_TYPE_LOAD} : iaddr_q));
  assign daddr_d = (frozen_q || !(ic_hit || ld_hit || st_hit)) ?
    daddr_q : {1'b0, ic_hit, ld_hit, st_hit, 20'h00000,
    miss_pa[`PCBC_PA_HI:`PCBC_PA_LO], 5'h00};

  // Read multiplexer.
  always_comb begin
    rdata_d = 64'h0000000000000000;
    if (sel_cnt) begin
      if (cp0_sel[0]) begin
        rdata_d = cnt_rd[cp0_sel[2:1]];
      end else begin
        rdata_d = {32'h00000000, ctl_rd[cp0_sel[2:1]]};
      end
    end else if (sel_cap && cp0_sel == `PCBC_SEL_CAP_CTRL) begin
      rdata_d = {43'h00000000000, cap_q};
    end else if (sel_cap && cp0_sel == `PCBC_SEL_CAP_IADDR) begin
      rdata_d = iaddr_q;
    end else if (sel_cap && cp0_sel == `PCBC_SEL_CAP_DADDR) begin
      rdata_d = daddr_q;
    end
  end

  // Status outputs and read data.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frozen_q <= 1'b0;
      irq_q <= 1'b0;
      cause_pending_q <= 1'b0;
      cp0_rdata_q <= 64'h0000000000000000;
    end else begin
      frozen_q <= freeze_d;
      irq_q <= irq_d;
      cause_pending_q <= irq_d;
      cp0_rdata_q <= rdata_d;
    end
  end

  // Capture control and address registers.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_q <= '0;
      iaddr_q <= 64'h0000000000000000;
      daddr_q <= 64'h0000000000000000;
    end else begin
      if (cap_we) begin
        cap_q <= cp0_wdata[`PCBC_CAP_WIDTH-1:0];
      end
      iaddr_q <= iaddr_d;
      daddr_q <= daddr_d;
    end
  end
endmodule : pcbc_monitor

/* rtl/pcbc_defs.svh */
// Register numbers and selects, field positions and type codes of the performance monitor.
`ifndef PCBC_DEFS_SVH
`define PCBC_DEFS_SVH
`define PCBC_REG_COUNTERS 5'h19
`define PCBC_REG_CAPTURE 5'h16
`define PCBC_SEL_CAP_CTRL 3'h0
`define PCBC_SEL_CAP_IADDR 3'h1
`define PCBC_SEL_CAP_DADDR 3'h2
`define PCBC_CTL_PRESET 31
`define PCBC_CTL_FREEZE 30
`define PCBC_CTL_EVT_HI 10
`define PCBC_CTL_EVT_LO 5
`define PCBC_CTL_IRQ_EN 4
`define PCBC_CTL_USER 3
`define PCBC_CTL_SUPER 2
`define PCBC_CTL_KERNEL 1
`define PCBC_CTL_EXL 0
`define PCBC_CNT_CARRY 40
`define PCBC_CNT_TOP 39
`define PCBC_CAP_WIDTH 21
`define PCBC_CAP_CWI 20
`define PCBC_CAP_CWD 19
`define PCBC_CAP_IFETCH 18
`define PCBC_CAP_READ 17
`define PCBC_CAP_WRITE 16
`define PCBC_CAP_BWI 15
`define PCBC_CAP_BCOND 14
`define PCBC_CAP_BUNCOND 13
`define PCBC_CAP_BINDIR 12
`define PCBC_CAP_BRET 11
`define PCBC_CAP_BCALL 10
`define PCBC_CAP_ONT 9
`define PCBC_CAP_OT 8
`define PCBC_CAP_PN 7
`define PCBC_CAP_PT 6
`define PCBC_CAP_CW 5
`define PCBC_CAP_CC 4
`define PCBC_IRQ_LINE 5
`define PCBC_CAUSE_PENDING_BIT 7
`define PCBC_TYPE_NOTTAKEN 2'h0
`define PCBC_TYPE_TAKEN 2'h1
`define PCBC_TYPE_LOAD 2'h2
`define PCBC_PA_HI 39
`define PCBC_PA_LO 5
`endif

/* rtl/pcbc_pkg.sv */
// Types shared by the performance monitor files.
package pcbc_pkg;
  typedef enum logic [2:0] {
    PCBC_BR_COND,
    PCBC_BR_UNCOND,
    PCBC_BR_INDIRECT,
    PCBC_BR_CALL,
    PCBC_BR_RETURN
  } pcbc_br_class_t;
  typedef enum logic [1:0] {
    PCBC_MODE_USER,
    PCBC_MODE_SUPER,
    PCBC_MODE_KERNEL
  } pcbc_mode_t;
endpackage : pcbc_pkg

/* rtl/pcbc_counter.sv */
// One 41-bit event counter with its control register.
`timescale 1ns/1ps
`include "pcbc_defs.svh"
module pcbc_counter
  import pcbc_pkg::*;
#(
  parameter int CW = 41,
  parameter int EW = 8,
  parameter logic PRESET = 1'b1
) (
  input wire logic clk, // Core clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic [63:0] ev_values, // Per-event active flags.
  input wire logic [EW-1:0] ev_amount [64], // Amount of each event.
  input wire logic mode_ok_u, // Core is in user mode.
  input wire logic mode_ok_s, // Core is in supervisor mode.
  input wire logic mode_ok_k, // Core is in kernel mode.
  input wire logic mode_ok_x, // Exception level active.
  input wire logic freeze, // Global freeze.
  input wire logic ctl_we, // Write control register.
  input wire logic cnt_we, // Write counter register.
  input wire logic [63:0] wdata, // Write data.
  output logic [31:0] ctl_rd, // Control read value.
  output logic [63:0] cnt_rd, // Counter read value.
  output logic carry_q, // Carry flag.
  output logic freeze_en_q, // Freeze enable bit.
  output logic irq_en_q // Overflow interrupt enable.
);
  logic [CW-2:0] count_q;
  logic [CW-2:0] count_d;
  logic carry_d;
  logic [5:0] evt_q;
  logic [3:0] modes_q;
  logic mode_hit;
  logic [CW-1:0] sum;
  logic [CW-2:0] inc;

  // Mode gating and the selected event's amount.
  assign mode_hit = (modes_q[`PCBC_CTL_USER] & mode_ok_u) |
    (modes_q[`PCBC_CTL_SUPER] & mode_ok_s) |
    (modes_q[`PCBC_CTL_KERNEL] & mode_ok_k) |
    (modes_q[`PCBC_CTL_EXL] & mode_ok_x);
  assign inc = (mode_hit && ev_values[evt_q]) ?
    (CW-1)'(ev_amount[evt_q]) : '0;
  assign sum = {1'b0, count_q} + {1'b0, inc};

  // Next count: software write wins, freeze holds every counter.
  assign count_d = cnt_we ? wdata[CW-2:0] :
    (freeze ? count_q : sum[CW-2:0]);
  assign carry_d = cnt_we ? wdata[`PCBC_CNT_CARRY] :
    (carry_q | (~freeze & sum[CW-1]));

  // Counter state; count field is left at zero for determinism.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
      carry_q <= 1'b1;
    end else begin
      count_q <= count_d;
      carry_q <= carry_d;
    end
  end

  // Control register fields.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      freeze_en_q <= 1'b1;
      irq_en_q <= 1'b0;
      evt_q <= '0;
      modes_q <= '0;
    end else if (ctl_we) begin
      freeze_en_q <= wdata[`PCBC_CTL_FREEZE];
      irq_en_q <= wdata[`PCBC_CTL_IRQ_EN];
      evt_q <= wdata[`PCBC_CTL_EVT_HI:`PCBC_CTL_EVT_LO];
      modes_q <= wdata[`PCBC_CTL_USER:`PCBC_CTL_EXL];
    end
  end

  // Read views; reserved bits return zero.
  assign ctl_rd = {PRESET, freeze_en_q, 19'h00000, evt_q, irq_en_q,
    modes_q};
  assign cnt_rd = {23'h000000, carry_q, count_q};
endmodule : pcbc_counter

/* verif/pcbc_monitor_asserts.sv */
// Port-level checker of the performance monitor.
`timescale 1ns/1ps
module pcbc_monitor_asserts
  import pcbc_pkg::*;
(
  input wire logic clk, // Core clock.
  input wire logic reset_n, // Reset, active low.
  input wire logic cp0_we, // Write strobe.
  input wire logic [4:0] cp0_reg, // Register number.
  input wire logic [2:0] cp0_sel, // Select.
  input wire logic [3:0] cp0_sel_hi, // Upper select bits.
  input wire logic [63:0] cp0_rdata_q, // Read data.
  input wire logic irq_q, // Overflow interrupt.
  input wire logic cause_pending_q, // Cause pending bit.
  input wire logic frozen_q // Freeze state.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Reads of the counter bank, split into control and count selects.
  wire logic rd25 = cp0_reg == 5'h19 && cp0_sel_hi == 4'h0;
  wire logic rd_ctl = rd25 && !cp0_sel[0];
  wire logic rd_cnt = rd25 && cp0_sel[0];
  wire logic quiet = !cp0_we;
  // Interrupt, freeze and read-back relations.
  property p_cause; irq_q |-> ##[0:1] cause_pending_q; endproperty
  a_cause: assert property (p_cause)
    else $error("cause pending bit not set");
  property p_resv; cp0_sel_hi != 4'h0 |=> cp0_rdata_q == 64'h0; endproperty
  a_resv: assert property (p_resv)
    else $error("reserved select not zero");
  property p_ctl_zero; rd_ctl |=> cp0_rdata_q[29:11] == 19'h0; endproperty
  a_ctl_zero: assert property (p_ctl_zero)
    else $error("control zero field not zero");
  property p_cnt_zero; rd_cnt |=> cp0_rdata_q[63:41] == 23'h0; endproperty
  a_cnt_zero: assert property (p_cnt_zero)
    else $error("counter upper bits not zero");
  property p_preset;
    rd_ctl |=> cp0_rdata_q[31] == ($past(cp0_sel) != 3'h6);
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset flag wrong");
  property p_hold;
    frozen_q && quiet && rd_cnt ##1 frozen_q && quiet && rd_cnt &&
      $stable(cp0_sel) |=> $stable(cp0_rdata_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved while frozen");
  property p_irq_hold; irq_q && quiet && !$past(cp0_we) |=> irq_q; endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without write");
  property p_frz_hold;
    frozen_q && quiet && !$past(cp0_we) |=> frozen_q;
  endproperty
  a_frz_hold: assert property (p_frz_hold)
    else $error("freeze dropped without write");
  property p_rst_frz; $rose(reset_n) |-> ##[1:2] frozen_q; endproperty
  a_rst_frz: assert property (p_rst_frz)
    else $error("no freeze after reset");
  c_irq: cover property ($rose(irq_q));
  c_thaw: cover property ($fell(frozen_q));
  c_resv: cover property (cp0_we && cp0_sel_hi != 4'h0);
endmodule : pcbc_monitor_asserts
bind pcbc_monitor pcbc_monitor_asserts u_chk (.clk, .reset_n, .cp0_we,
  .cp0_reg, .cp0_sel, .cp0_sel_hi, .cp0_rdata_q, .irq_q, .cause_pending_q,
  .frozen_q);

/* verif/pcbc_monitor_bench.sv */
// Self-checking bench of the performance monitor.
`timescale 1ns/1ps
`define CK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module pcbc_monitor_bench
  import pcbc_pkg::*;
;
  localparam logic [63:0] ONES = 64'hFFFF_FFFF_FFFF_FFFF;
  logic clk, reset_n, cp0_we, exl_active, br_valid, br_pred_taken, br_taken;
  logic br_mispredict, iwatch_hit, dwatch_hit, ic_miss, dc_load, dc_store;
  logic irq_q, cause_pending_q, frozen_q;
  logic [4:0] cp0_reg;
  logic [2:0] cp0_sel;
  logic [3:0] cp0_sel_hi;
  logic [63:0] cp0_wdata, cp0_rdata_q, ev_values, br_pc, load_pc, rv, v1, last;
  logic [39:0] miss_pa;
  logic [7:0] ev_amount [64];
  pcbc_mode_t mode;
  pcbc_br_class_t br_class;
  int fails, num_checks;
  pcbc_monitor u_dut (.*);
  // Core clock.
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Register write, select given as {upper, lower}.
  task automatic wr(input logic [4:0] r, input logic [6:0] s,
                    input logic [63:0] d);
    @(posedge clk);
    cp0_we <= 1'h1;
    cp0_reg <= r;
    {cp0_sel_hi, cp0_sel} <= s;
    cp0_wdata <= d;
    @(posedge clk);
    cp0_we <= 1'h0;
  endtask : wr
  // Register read; data is registered one cycle behind the address.
  task automatic rd(input logic [4:0] r, input logic [6:0] s);
    @(posedge clk);
    cp0_reg <= r;
    {cp0_sel_hi, cp0_sel} <= s;
    @(posedge clk);
    #1 rv = cp0_rdata_q;
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  // Event 3 active for n cycles, worth 5 each.
  task automatic pulse(input int n);
    @(posedge clk);
    ev_values[3] <= 1'h1;
    repeat (n) @(posedge clk);
    ev_values[3] <= 1'h0;
  endtask : pulse
  // One branch; f is {predicted taken, taken, mispredict, watch hit}.
  task automatic br(input logic [63:0] ctl, input pcbc_br_class_t c,
                    input logic [3:0] f, input logic [63:0] pc,
                    input logic hit);
    wr(5'h16, 7'h0, ctl);
    @(posedge clk);
    br_valid <= 1'h1;
    br_class <= c;
    {br_pred_taken, br_taken, br_mispredict, iwatch_hit} <= f;
    br_pc <= pc;
    @(posedge clk);
    br_valid <= 1'h0;
    if (hit) last = {pc[63:2], 1'h0, f[2]};
    rd(5'h16, 7'h1);
    `CK("branch address", last, rv)
  endtask : br
  task automatic t_reset;
    rd(5'h19, 7'h0);
    `CK("ctl reset", 3'h6, {rv[31:30], rv[4]})
    rd(5'h19, 7'h6);
    `CK("last preset", 1'h0, rv[31])
    rd(5'h19, 7'h1);
    `CK("count reset", 64'h0000_0100_0000_0000, rv)
    `CK("reset freeze", 1'h1, frozen_q)
  endtask : t_reset
  task automatic t_regs;
    wr(5'h19, 7'h0, ONES);
    wr(5'h19, 7'h8, 64'h0);
    rd(5'h19, 7'h0);
    `CK("ctl mask", 32'hC000_07FF, rv[31:0])
    wr(5'h19, 7'h1, ONES);
    rd(5'h19, 7'h1);
    `CK("count mask", 64'h0000_01FF_FFFF_FFFF, rv)
    rd(5'h19, 7'h9);
    `CK("reserved read", 64'h0, rv)
  endtask : t_regs
  task automatic t_count;
    for (int i = 0; i < 4; i++) begin
      wr(5'h19, 7'(2 * i), 64'h68);
      wr(5'h19, 7'(2 * i + 1), 64'h0);
    end
    settle(3);
    `CK("thawed", 1'h0, frozen_q)
    pulse(4);
    rd(5'h19, 7'h1);
    `CK("user count", 64'h14, rv)
    rd(5'h19, 7'h3);
    `CK("second counter", 64'h14, rv)
    @(posedge clk);
    mode <= PCBC_MODE_SUPER;
    pulse(4);
    rd(5'h19, 7'h1);
    `CK("super count", 64'h14, rv)
    @(posedge clk);
    mode <= PCBC_MODE_USER;
  endtask : t_count
  task automatic t_ovf;
    wr(5'h19, 7'h0, 64'h4000_0078);
    wr(5'h19, 7'h1, 64'h0000_00FF_FFFF_FFFE);
    pulse(1);
    settle(3);
    `CK("overflow flags", 3'h7, {irq_q, cause_pending_q, frozen_q})
    rd(5'h19, 7'h1);
    `CK("overflow", 64'h0000_0100_0000_0003, rv)
    rd(5'h19, 7'h3);
    v1 = rv;
    pulse(3);
    rd(5'h19, 7'h3);
    `CK("frozen count", v1, rv)
    wr(5'h19, 7'h1, 64'h0);
    settle(3);
    `CK("released", 2'h0, {irq_q, frozen_q})
    wr(5'h19, 7'h0, 64'h68);
    wr(5'h19, 7'h1, 64'h0000_00FF_FFFF_FFFE);
    pulse(2);
    settle(3);
    `CK("no freeze", 2'h0, {irq_q, frozen_q})
    rd(5'h19, 7'h1);
    `CK("keeps counting", 64'h0000_0100_0000_0008, rv)
  endtask : t_ovf
  task automatic t_branch;
    last = 64'h0;
    br(64'h7FF8, PCBC_BR_COND, 4'h6, 64'h1000, 1'h1);
    br(64'h7F58, PCBC_BR_COND, 4'hE, 64'h2000, 1'h0);
    br(64'h7F58, PCBC_BR_UNCOND, 4'h6, 64'h3000, 1'h1);
    br(64'h7FB8, PCBC_BR_COND, 4'hC, 64'h3800, 1'h0);
    br(64'h7DF8, PCBC_BR_COND, 4'h0, 64'h4000, 1'h0);
    br(64'h7BF8, PCBC_BR_CALL, 4'h4, 64'h5000, 1'h0);
    br(64'hFFF8, PCBC_BR_COND, 4'hC, 64'h6000, 1'h0);
    br(64'hFFF8, PCBC_BR_COND, 4'hD, 64'h7000, 1'h1);
    br(64'h7FF8, PCBC_BR_COND, 4'h0, 64'h9000, 1'h1);
    @(posedge clk);
    mode <= PCBC_MODE_SUPER;
    br(64'h7FF8, PCBC_BR_COND, 4'h4, 64'h8000, 1'h0);
  endtask : t_branch
  task automatic t_cache;
    wr(5'h16, 7'h0, 64'h2_0002);
    @(posedge clk);
    dc_load <= 1'h1;
    load_pc <= 64'hA000;
    miss_pa <= 40'h12_3456_7890;
    @(posedge clk);
    dc_load <= 1'h0;
    rd(5'h16, 7'h2);
    `CK("load line", 64'h2000_0012_3456_7880, rv)
    rd(5'h16, 7'h1);
    `CK("load address", 64'hA002, rv)
    @(posedge clk);
    dc_store <= 1'h1;
    miss_pa <= 40'h55_0000_0000;
    @(posedge clk);
    dc_store <= 1'h0;
    rd(5'h16, 7'h2);
    `CK("store skipped", 64'h2000_0012_3456_7880, rv)
  endtask : t_cache
  task automatic end_of_test;
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  // Watchdog against a hung sequence.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    {reset_n, cp0_we, exl_active, br_valid, br_pred_taken, br_taken} = '0;
    {br_mispredict, iwatch_hit, dwatch_hit, ic_miss, dc_load, dc_store} = '0;
    {cp0_reg, cp0_sel, cp0_sel_hi, miss_pa} = '0;
    {cp0_wdata, ev_values, br_pc, load_pc} = '0;
    mode = PCBC_MODE_USER;
    br_class = PCBC_BR_COND;
    foreach (ev_amount[i]) ev_amount[i] = 8'h05;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    t_reset();
    t_regs();
    t_count();
    t_ovf();
    t_branch();
    @(posedge clk);
    mode <= PCBC_MODE_KERNEL;
    t_cache();
    end_of_test();
  end
endmodule : pcbc_monitor_bench
